// file: hdl/piu_pkg.sv
// piu_pkg: constants and types shared by the priority interrupt unit,
// its controller end and the testbench.
// assumes one 50 MHz clock pclk and an asynchronous active-low presetn.
//
// Function
// R1: latch requests, encode highest active one
// R2: compare encoded level with current status
// R3: acknowledge low for exactly one cycle
// R4: acknowledge needs request, strobe, group, undisabled
// R5: acknowledge sets disable, beating load clear
// R6: acknowledge freezes request latch until load
// R7: completed status load clears disable
// R8: loaded level blocks that and lower levels
// R9: level read enable drives level bus
// R10: next-group enable when chain in, no group, idle
// R11: chained units pass group enable downstream
// R12: level and acknowledge lines only pull low
// R13: controller strobes at end of each instruction; here irq_strobe_en is ctrl bit 0, held at the level software writes
// R14: handler reads level, writes it back
// R15: handler restores prior level on exit
// R16: line zero lowest, line seven highest
// R17: status is three-bit level, active low
// R18: group select low: status in this group
// R19: latches transparent while loading, not acknowledging
// R20: open-collector outputs modelled as drive enables
package piu_pkg;
  // ---------------------------------------------------------------------
  // register map of the controller end (byte offsets on apb, 4 apart)
  // ---------------------------------------------------------------------
  localparam logic [11:0] PIU_CTRL_OFS   = 12'h000;
  localparam logic [11:0] PIU_STATUS_OFS = 12'h004;
  localparam logic [11:0] PIU_CMD_OFS    = 12'h008;
  localparam logic [11:0] PIU_LEVEL_OFS  = 12'h00c;

  // ctrl fields
  localparam int PIU_CTRL_STB_BIT   = 0;
  localparam int PIU_CTRL_GRP_BIT   = 1;
  localparam int PIU_CTRL_LVL_LSB   = 4;
  // cmd fields: write 1 to start an action
  localparam int PIU_CMD_LOAD_BIT   = 0;
  localparam int PIU_CMD_READ_BIT   = 1;
  // status fields
  localparam int PIU_ST_ACK_BIT     = 0;
  localparam int PIU_ST_BUSY_BIT    = 1;
  localparam int PIU_ST_LVL_LSB     = 4;

  localparam logic [31:0] PIU_CTRL_RST = 32'h0000_0000;
  localparam logic [2:0]  PIU_LVL_RST  = 3'h0;

  typedef enum logic [1:0] {PIU_IDLE, PIU_DRIVE, PIU_DONE} piu_state_t;
endpackage

// file: hdl/piu_link_if.sv
// piu_link_if: wires between one priority unit and its controller.
// assumes the bench resolves open-collector lines from the drive enables.
`timescale 1ns/1ps
interface piu_link_if;
  logic [7:0] irq_req_n;
  logic [2:0] cur_status_in_n;
  logic       status_group_sel_n;
  logic       status_load_en_n;
  logic       irq_strobe_en;
  logic       level_read_en_n;
  logic       group_enable_in;
  logic       group_enable_out;
  logic       irq_ack_oe;
  logic [2:0] req_level_oe;
  logic       irq_ack_n;
  logic [2:0] req_level_out_n;

  modport unit (input irq_req_n, cur_status_in_n, status_group_sel_n, status_load_en_n,
                input irq_strobe_en, level_read_en_n, group_enable_in,
                input irq_ack_n, req_level_out_n,
                output group_enable_out, irq_ack_oe, req_level_oe);
  modport ctrl (output cur_status_in_n, status_group_sel_n, status_load_en_n,
                output irq_strobe_en, level_read_en_n,
                input irq_ack_n, req_level_out_n, group_enable_out);
endinterface

// file: hdl/piu_prio_enc.sv
// piu_prio_enc: highest active request, line seven above line zero.
// assumes active-high request vector.
`timescale 1ns/1ps
module piu_prio_enc #(
  parameter int N = 8,
  parameter int W = 3
) (
  input  wire logic [N-1:0] req,
  output logic      [W-1:0] level,
  output logic              any
);
  always_comb begin
    level = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i]) begin
        level = W'(i); // [R16]
      end
    end
  end
  assign any = |req;
endmodule

// file: hdl/piu_unit.sv
// piu_unit: eight-level priority interrupt unit.
// assumes inputs synchronous to pclk; irq_req_n driven by the bench.
`timescale 1ns/1ps
module piu_unit
  import piu_pkg::*;
#(
  parameter int NREQ = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  piu_link_if.unit link
);
  // ---------------------------------------------------------------------
  // latches
  // ---------------------------------------------------------------------
  logic [NREQ-1:0] req_latch;
  logic [2:0]      status;
  logic            in_group;
  logic            ack;
  logic            disable_ff;
  logic            group_out;
  logic [2:0]      level_oe;

  wire       load      = !link.status_load_en_n;
  wire [2:0] top_level;
  wire       any_req;
  // an acknowledge freezes the request latch until the next status load [R6] [R19]
  wire       req_open  = !ack && !disable_ff;
  wire [NREQ-1:0] req_now = req_open ? ~link.irq_req_n : req_latch;

  piu_prio_enc #(.N(NREQ), .W(3)) u_enc (
    .req   (req_now),
    .level (top_level),
    .any   (any_req)
  ); // [R1]

  // level above status only when status is in this group [R2] [R8] [R18]
  wire above  = any_req && (!in_group || (top_level > status));
  wire next_ack = above && link.irq_strobe_en && link.group_enable_in && !disable_ff && !ack; // [R4]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_latch <= '0;
    end else if (req_open) begin
      req_latch <= ~link.irq_req_n; // [R1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status   <= PIU_LVL_RST;
      in_group <= 1'b0;
    end else if (load) begin
      status   <= ~link.cur_status_in_n; // [R17]
      in_group <= !link.status_group_sel_n; // [R19]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack; // [R3]
    end
  end

  // set wins over the load clear [R5] [R7]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disable_ff <= 1'b0;
    end else if (next_ack || ack) begin
      disable_ff <= 1'b1;
    end else if (load) begin
      disable_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // outputs: ack and level as drive enables, line pulled low when enabled; group enable out driven directly
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_out <= 1'b0;
      level_oe  <= '0;
    end else begin
      group_out <= link.group_enable_in && !in_group && !any_req; // [R10] [R11]
      // an enabled driver pulls its line low, so a set level bit maps to an enabled driver
      level_oe  <= (!link.level_read_en_n && link.group_enable_in && any_req) ? top_level : 3'h0; // [R9] [R12]
    end
  end

  assign link.irq_ack_oe       = ack; // [R12] [R20]
  assign link.req_level_oe     = level_oe; // [R20]
  assign link.group_enable_out = group_out;
endmodule

// file: hdl/piu_ctrl.sv
// piu_ctrl: apb-driven controller end of the priority unit link.
// assumes a single apb master; pready is always high (zero wait).
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module piu_ctrl
  import piu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  piu_link_if.ctrl         link
);
  logic [31:0] ctrl;
  logic        ack_seen;
  logic [2:0]  level;
  logic        load_n;
  logic        read_n;
  logic [1:0]  hold;
  piu_state_t  state;

  wire wr      = psel && penable && pwrite;
  wire rd      = psel && !penable && !pwrite;
  wire wr_ctrl = wr && (paddr == PIU_CTRL_OFS);
  wire wr_cmd  = wr && (paddr == PIU_CMD_OFS) && (state == PIU_IDLE);
  wire mapped  = (paddr == PIU_CTRL_OFS) || (paddr == PIU_STATUS_OFS) ||
                 (paddr == PIU_CMD_OFS) || (paddr == PIU_LEVEL_OFS);
  wire [31:0] status_word = {25'h0, level, 2'h0, (state != PIU_IDLE), ack_seen};
  wire [31:0] rd_word = (paddr == PIU_CTRL_OFS)   ? ctrl :
                        (paddr == PIU_STATUS_OFS) ? status_word :
                        (paddr == PIU_LEVEL_OFS)  ? {29'h0, level} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= PIU_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      prdata  <= rd ? rd_word : prdata;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // acknowledge pulse is sticky; a new one wins over a status read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_seen <= 1'b0;
    end else if (!link.irq_ack_n) begin
      ack_seen <= 1'b1;
    end else if (psel && penable && !pwrite && paddr == PIU_STATUS_OFS) begin
      ack_seen <= 1'b0;
    end
  end

  // one-shot load or read strobe, held two cycles so the bus settles [R13] [R14] [R15]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= PIU_IDLE;
      load_n <= 1'b1;
      read_n <= 1'b1;
      hold   <= 2'h0;
      level  <= PIU_LVL_RST;
    end else begin
      case (state)
        PIU_IDLE: begin
          if (wr_cmd && (pwdata[PIU_CMD_LOAD_BIT] || pwdata[PIU_CMD_READ_BIT])) begin
            load_n <= !pwdata[PIU_CMD_LOAD_BIT];
            read_n <= !pwdata[PIU_CMD_READ_BIT];
            hold   <= 2'h1;
            state  <= PIU_DRIVE;
          end
        end
        PIU_DRIVE: begin
          if (hold == 2'h0) begin
            if (!read_n) begin
              level <= ~link.req_level_out_n;
            end
            load_n <= 1'b1;
            read_n <= 1'b1;
            state  <= PIU_DONE;
          end else begin
            hold <= hold - 2'h1;
          end
        end
        PIU_DONE: state <= PIU_IDLE;
        default:  state <= PIU_IDLE;
      endcase
    end
  end

  assign link.irq_strobe_en      = ctrl[PIU_CTRL_STB_BIT];
  assign link.status_group_sel_n = !ctrl[PIU_CTRL_GRP_BIT]; // [R18]
  assign link.cur_status_in_n    = ~ctrl[PIU_CTRL_LVL_LSB +: 3]; // [R17]
  assign link.status_load_en_n   = load_n;
  assign link.level_read_en_n    = read_n;
endmodule

// file: testbench/piu_assertions.sv
// piu_assertions: checks on the link between the unit and its controller.
// assumes it sees the link signals of one unit and one controller.
`timescale 1ns/1ps
module piu_assertions (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [7:0] irq_req_n,
  input wire logic       status_load_en_n,
  input wire logic       irq_strobe_en,
  input wire logic       level_read_en_n,
  input wire logic       group_enable_in,
  input wire logic       group_enable_out,
  input wire logic       irq_ack_oe,
  input wire logic [2:0] req_level_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ack_pulse_a: assert property (irq_ack_oe |=> !irq_ack_oe)
    else $error("ack held past one cycle");
  ack_strobe_a: assert property (irq_ack_oe |-> $past(irq_strobe_en))
    else $error("ack without strobe enable");
  ack_group_a: assert property (!group_enable_in |=> !irq_ack_oe)
    else $error("ack without group enable");
  ack_block_a: assert property (irq_ack_oe ##1 status_load_en_n |=> !irq_ack_oe)
    else $error("ack repeated before status load");
  chain_out_a: assert property (group_enable_out |-> $past(group_enable_in && &irq_req_n))
    else $error("next group enabled while blocked");
  level_drive_a: assert property (|req_level_oe |-> $past(!level_read_en_n && group_enable_in))
    else $error("level bus driven without read enable");
  load_width_a: assert property ($fell(status_load_en_n) |=> !status_load_en_n ##1 status_load_en_n)
    else $error("status load strobe width wrong");
  read_width_a: assert property ($fell(level_read_en_n) |=> !level_read_en_n ##1 level_read_en_n)
    else $error("level read strobe width wrong");
endmodule

// file: testbench/priority_interrupt_unit_test.sv
// priority_interrupt_unit_test: unit and controller joined by the link.
// assumes one unit, so the wired lines are resolved here from the enables.
`timescale 1ns/1ps
module priority_interrupt_unit_test;
  import piu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int num_errors = 0, n_compared = 0, n;
  piu_link_if link ();
  assign link.irq_ack_n = ~link.irq_ack_oe;
  assign link.req_level_out_n = ~link.req_level_oe;
  always #10 pclk = ~pclk;
  piu_unit piu_unit_i (.pclk(pclk), .presetn(presetn), .link(link.unit));
  piu_ctrl piu_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.ctrl));
  piu_assertions piu_assertions_i (.pclk(pclk), .presetn(presetn), .irq_req_n(link.irq_req_n),
    .status_load_en_n(link.status_load_en_n), .irq_strobe_en(link.irq_strobe_en),
    .level_read_en_n(link.level_read_en_n), .group_enable_in(link.group_enable_in),
    .group_enable_out(link.group_enable_out), .irq_ack_oe(link.irq_ack_oe), .req_level_oe(link.req_level_oe));
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // command strobes last 2 cycles, busy drops 1 later: 8 cycles is ample
  task automatic command(input logic [31:0] c);
    apb(1, PIU_CMD_OFS, c);
    repeat (8) @(posedge pclk);
  endtask
  task automatic count_acks();
    n = 0;
    repeat (20) @(negedge pclk) if (link.irq_ack_n === 1'b0) n++;
    // hand back on a rising edge so the next stimulus lands there
    @(posedge pclk);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    link.irq_req_n = 8'hff;
    link.group_enable_in = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, PIU_CTRL_OFS, 32'h0);
    cmp("ctrl reset", PIU_CTRL_RST, rd);
    apb(0, 12'h010, 32'h0);
    cmp("unmapped error", 32'h1, {31'h0, err});
    apb(1, PIU_CTRL_OFS, 32'h3);
    command(32'h1);
    for (int lvl = 1; lvl < 8; lvl++) begin
      // every line up to lvl requests; status is lvl-1, so only lvl wins
      link.irq_req_n <= ~(8'hff >> (7 - lvl));
      count_acks();
      cmp("ack cycles", 32'h1, n);
      link.irq_req_n <= 8'hff;
      command(32'h2);
      apb(0, PIU_LEVEL_OFS, 32'h0);
      cmp("level", lvl, {29'h0, rd[2:0]});
      link.irq_req_n <= ~(8'hff >> (7 - lvl));
      apb(1, PIU_CTRL_OFS, 32'h3 | (lvl << 4));
      command(32'h1);
      count_acks();
      cmp("blocked acks", 32'h0, n);
    end
    link.irq_req_n <= 8'hff;
    apb(1, PIU_CTRL_OFS, 32'h1);
    command(32'h1);
    @(negedge pclk);
    cmp("next group on", 32'h1, {31'h0, link.group_enable_out});
    @(posedge pclk);
    link.group_enable_in <= 1'b0;
    repeat (2) @(negedge pclk);
    cmp("next group off", 32'h0, {31'h0, link.group_enable_out});
    @(posedge pclk);
    link.irq_req_n <= 8'hdf;
    count_acks();
    cmp("chain blocked acks", 32'h0, n);
    link.group_enable_in <= 1'b1;
    count_acks();
    cmp("out of group acks", 32'h1, n);
    link.irq_req_n <= 8'hff;
    command(32'h2);
    apb(0, PIU_STATUS_OFS, 32'h0);
    cmp("status after ack", 32'h51, rd);
    apb(0, PIU_STATUS_OFS, 32'h0);
    cmp("status cleared", 32'h50, rd);
    apb(1, PIU_CTRL_OFS, 32'h53);
    command(32'h1);
    // leaving the handler puts back a lower level, so level five wins again
    apb(1, PIU_CTRL_OFS, 32'h23);
    command(32'h1);
    link.irq_req_n <= 8'hdf;
    count_acks();
    cmp("restored level acks", 32'h1, n);
    summarize();
  end
  initial begin
    #100us;
    num_errors++;
    summarize();
  end
endmodule
